// *** design/pbmc_top.sv ***
// basic mode control register bank of a 10/100 transceiver
// assumes straps are pins, all other inputs are on ref_clk
`timescale 1ns/1ps
`include "pbmc_cfg.svh"
module pbmc_top (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  // register port
  input  wire pbmc_pkg::pbmc_addr_type reg_addr,
  input  wire pbmc_pkg::pbmc_word_type reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output pbmc_pkg::pbmc_word_type      reg_rdata,
  output logic                        irq,
  // strap pins
  input  wire logic                   strap_autoneg_en,
  input  wire logic                   strap_speed_100,
  input  wire logic                   strap_full_duplex,
  // status from the transceiver core
  input  wire logic                   an_speed_100,
  input  wire logic                   an_full_duplex,
  input  wire logic                   link_ok,
  input  wire logic                   polarity_inverted,
  input  wire logic                   selftest_error,
  input  wire logic                   energy_power_state,
  input  wire logic                   energy_error_met_in,
  input  wire logic                   energy_data_met_in,
  // mac-side data
  input  wire logic [3:0]             mac_txd,
  input  wire logic                   mac_tx_en,
  input  wire logic [3:0]             line_rxd,
  input  wire logic                   line_rx_dv,
  output logic [3:0]                  mac_rxd,
  output logic                        mac_rx_dv,
  // core controls
  output logic                        speed_100,
  output logic                        full_duplex,
  output logic                        autoneg_enable,
  output logic                        core_enable,
  output logic                        isolate,
  output logic                        loopback,
  output logic [2:0]                  tenbase_ctrl,
  output logic [4:0]                  selftest_ctrl,
  output logic [12:0]                 energy_ctrl
);
  import pbmc_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int SWRST_CYC  = `PBMC_SWRST_CYCLES;
  localparam int SWRST_LAST = SWRST_CYC + 2;
  logic                  strap_an_s1, strap_an_s2;
  logic                  strap_sp_s1, strap_sp_s2;
  logic                  strap_dx_s1, strap_dx_s2;
  logic                  loopback_ff, speed_sel_ff, autoneg_en_ff;
  logic                  power_down_ff, isolate_ff, duplex_sel_ff;
  pbmc_word_type         tenbase_ff, selftest_cfg_ff, energy_cfg_ff;
  logic [7:0]            tally_ff;
  logic [`PBMC_IRQ_W-1:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat;
  logic [`PBMC_IRQ_W-1:0] irq_event;
  pbmc_word_type         reg_rdata_ff, nxt_rdata;
  logic                  irq_ff, speed_100_ff, full_duplex_ff;
  logic                  core_enable_ff, mac_rx_dv_ff;
  logic [3:0]            mac_rxd_ff;
  logic                  rst_busy, rst_done, rst_start;
  logic                  wr_basic, wr_irq_stat, wr_irq_mask;
  logic                  wr_tenbase, wr_selftest, wr_energy;
  logic                  rd_selftest, rd_energy, rd_link;
  logic [1:0]            met_live, met_q;
  logic                  link_q, link_q_d_ff;

  // address match, used by both write and read decode
  function automatic logic hit(input pbmc_addr_type a,
                               input pbmc_addr_type off);
    hit = (a == off);
  endfunction

  // ****************************************************************
  // strap synchronisers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    strap_an_s1 <= strap_autoneg_en;
    strap_an_s2 <= strap_an_s1;
    strap_sp_s1 <= strap_speed_100;
    strap_sp_s2 <= strap_sp_s1;
    strap_dx_s1 <= strap_full_duplex;
    strap_dx_s2 <= strap_dx_s1;
  end

  // ****************************************************************
  // decode
  // ****************************************************************
  assign wr_basic    = reg_wr && hit(reg_addr, `PBMC_OFF_BASIC_CTRL);
  assign wr_irq_stat = reg_wr && hit(reg_addr, `PBMC_OFF_IRQ_STATUS);
  assign wr_irq_mask = reg_wr && hit(reg_addr, `PBMC_OFF_IRQ_MASK);
  assign wr_tenbase  = reg_wr && hit(reg_addr, `PBMC_OFF_TENBASE);
  assign wr_selftest = reg_wr && hit(reg_addr, `PBMC_OFF_SELFTEST);
  assign wr_energy   = reg_wr && hit(reg_addr, `PBMC_OFF_ENERGY);
  assign rd_selftest = reg_rd && hit(reg_addr, `PBMC_OFF_SELFTEST);
  assign rd_energy   = reg_rd && hit(reg_addr, `PBMC_OFF_ENERGY);
  assign rd_link     = reg_rd && hit(reg_addr, `PBMC_OFF_LINK_STATUS);
  // a one in bit 15 starts the reset unless one is running
  assign rst_start   = wr_basic && reg_wdata[`PBMC_BC_RESET]
                       && !rst_busy;

  // ****************************************************************
  // software reset sequencer
  // ****************************************************************
  pbmc_rst_seq #(
    .CYCLES (SWRST_CYC)
  ) u_rst_seq (
    .ref_clk (ref_clk),
    .srst    (srst),
    .start   (rst_start),
    .busy    (rst_busy),
    .done    (rst_done)
  );

  // ****************************************************************
  // basic mode control bits
  // ****************************************************************
  // power-on and software reset both take strap and default values
  always_ff @(posedge ref_clk) begin
    if (srst || rst_done) begin
      autoneg_en_ff <= strap_an_s2;
      speed_sel_ff  <= strap_sp_s2;
      duplex_sel_ff <= strap_dx_s2;
      loopback_ff   <= 1'b0;
      power_down_ff <= 1'b0;
      isolate_ff    <= 1'b0;
    end else if (wr_basic) begin
      loopback_ff   <= reg_wdata[`PBMC_BC_LOOP];
      speed_sel_ff  <= reg_wdata[`PBMC_BC_SPEED];
      autoneg_en_ff <= reg_wdata[`PBMC_BC_ANEN];
      power_down_ff <= reg_wdata[`PBMC_BC_PDOWN];
      isolate_ff    <= reg_wdata[`PBMC_BC_ISOLATE];
      duplex_sel_ff <= reg_wdata[`PBMC_BC_DUPLEX];
    end
  end

  // ****************************************************************
  // other configuration words, reserved and read-only bits masked
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst || rst_done) begin
      tenbase_ff      <= `PBMC_TENBASE_RST;
      selftest_cfg_ff <= `PBMC_SELFTEST_RST;
      energy_cfg_ff   <= `PBMC_ENERGY_RST;
    end else begin
      if (wr_tenbase) begin
        tenbase_ff <= reg_wdata & `PBMC_TENBASE_WMASK;
      end
      if (wr_selftest) begin
        selftest_cfg_ff <= reg_wdata & `PBMC_SELFTEST_WMASK;
      end
      if (wr_energy) begin
        energy_cfg_ff <= reg_wdata & `PBMC_ENERGY_WMASK;
      end
    end
  end

  // ****************************************************************
  // self-test error tally, saturating, cleared by its read
  // ****************************************************************
  // an error in the read cycle survives as a count of one
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tally_ff <= 8'h00;
    end else if (rd_selftest) begin
      tally_ff <= {7'h00, selftest_error};
    end else if (selftest_error && tally_ff != 8'hff) begin
      tally_ff <= tally_ff + 8'h01;
    end
  end

  // ****************************************************************
  // latched status bits
  // ****************************************************************
  assign met_live = {energy_error_met_in, energy_data_met_in};

  // both threshold flags latch high until the energy register is read
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_met
      pbmc_latch #(
        .ACTIVE (1'b1)
      ) u_met (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .live       (met_live[gi]),
        .rd_release (rd_energy),
        .value_ff   (met_q[gi])
      );
    end
  endgenerate

  // link status latches low until the link status register is read
  pbmc_latch #(
    .ACTIVE (1'b0)
  ) u_link (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .live       (link_ok),
    .rd_release (rd_link),
    .value_ff   (link_q)
  );

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link_q_d_ff <= 1'b1;
    end else begin
      link_q_d_ff <= link_q;
    end
  end

  assign irq_event[`PBMC_IRQ_SWRST]     = rst_done;
  assign irq_event[`PBMC_IRQ_SELFTEST]  = selftest_error;
  assign irq_event[`PBMC_IRQ_ERR_MET]   = energy_error_met_in;
  assign irq_event[`PBMC_IRQ_DATA_MET]  = energy_data_met_in;
  assign irq_event[`PBMC_IRQ_LINK_LOSS] = link_q_d_ff && !link_q;

  // write one clears, a new event in the same cycle wins
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_irq_stat) begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata[`PBMC_IRQ_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | irq_event;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
      if (wr_irq_mask) begin
        irq_mask_ff <= reg_wdata[`PBMC_IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // read data, valid only in the cycle after the read strobe
  // ****************************************************************
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `PBMC_OFF_BASIC_CTRL: begin
          nxt_rdata[`PBMC_BC_RESET]   = rst_busy;
          nxt_rdata[`PBMC_BC_LOOP]    = loopback_ff;
          nxt_rdata[`PBMC_BC_SPEED]   = speed_sel_ff;
          nxt_rdata[`PBMC_BC_ANEN]    = autoneg_en_ff;
          nxt_rdata[`PBMC_BC_PDOWN]   = power_down_ff;
          nxt_rdata[`PBMC_BC_ISOLATE] = isolate_ff;
          nxt_rdata[`PBMC_BC_DUPLEX]  = duplex_sel_ff;
        end
        `PBMC_OFF_TENBASE: begin
          nxt_rdata = tenbase_ff;
          nxt_rdata[`PBMC_TENBASE_POL] = polarity_inverted;
        end
        `PBMC_OFF_SELFTEST: begin
          nxt_rdata = selftest_cfg_ff;
          nxt_rdata[`PBMC_TALLY_LSB +: 8] = tally_ff;
        end
        `PBMC_OFF_ENERGY: begin
          nxt_rdata = energy_cfg_ff;
          nxt_rdata[`PBMC_ENERGY_POWER_STATE] = energy_power_state;
          nxt_rdata[`PBMC_ENERGY_ERROR_THRESHOLD_MET]   = met_q[1];
          nxt_rdata[`PBMC_ENERGY_DATA_THRESHOLD_MET]  = met_q[0];
        end
        `PBMC_OFF_LINK_STATUS: begin
          nxt_rdata[`PBMC_LS_LINK] = link_q;
          nxt_rdata[`PBMC_LS_PERM] = `PBMC_LS_PERM_VAL;
        end
        `PBMC_OFF_IRQ_STATUS: begin
          nxt_rdata[`PBMC_IRQ_W-1:0] = irq_stat_ff;
        end
        `PBMC_OFF_IRQ_MASK: begin
          nxt_rdata[`PBMC_IRQ_W-1:0] = irq_mask_ff;
        end
        default: begin
          nxt_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata_ff <= 16'h0000;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // operating mode and data path
  // ****************************************************************
  // forced speed and duplex apply only with auto-negotiation off
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      speed_100_ff   <= 1'b0;
      full_duplex_ff <= 1'b0;
      core_enable_ff <= 1'b0;
    end else begin
      speed_100_ff   <= autoneg_en_ff ? an_speed_100
                                      : speed_sel_ff;
      full_duplex_ff <= autoneg_en_ff ? an_full_duplex
                                      : duplex_sel_ff;
      core_enable_ff <= !power_down_ff;
    end
  end

  // isolation and power down silence the mac side; loopback feeds it
  always_ff @(posedge ref_clk) begin
    if (srst || isolate_ff || power_down_ff) begin
      mac_rxd_ff   <= 4'h0;
      mac_rx_dv_ff <= 1'b0;
    end else if (loopback_ff) begin
      mac_rxd_ff   <= mac_txd;
      mac_rx_dv_ff <= mac_tx_en;
    end else begin
      mac_rxd_ff   <= line_rxd;
      mac_rx_dv_ff <= line_rx_dv;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata      = reg_rdata_ff;
  assign irq            = irq_ff;
  assign speed_100      = speed_100_ff;
  assign full_duplex    = full_duplex_ff;
  assign autoneg_enable = autoneg_en_ff;
  assign core_enable    = core_enable_ff;
  assign isolate        = isolate_ff;
  assign loopback       = loopback_ff;
  assign mac_rxd        = mac_rxd_ff;
  assign mac_rx_dv      = mac_rx_dv_ff;
  // force link sits apart from heartbeat and jabber controls
  assign tenbase_ctrl   = {tenbase_ff[`PBMC_TENBASE_FORCE],
                           tenbase_ff[1:0]};
  assign selftest_ctrl  = selftest_cfg_ff[4:0];
  assign energy_ctrl    = {energy_cfg_ff[15:11], energy_cfg_ff[7:0]};

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence swrst_req_s;
    wr_basic && reg_wdata[`PBMC_BC_RESET] && !rst_busy;
  endsequence
  sequence swrst_end_s;
    ##[1:SWRST_LAST] $fell(rst_busy);
  endsequence

  swrst_clear_a: assert property (swrst_req_s |-> swrst_end_s)
    else $error("software reset bit did not clear in time");
  selfclr_read_a: assert property (
    reg_rd && hit(reg_addr, `PBMC_OFF_BASIC_CTRL) && rst_busy
    |=> reg_rdata_ff[`PBMC_BC_RESET])
    else $error("reset bit read zero while reset ran");
  restrap_done_a: assert property ($fell(rst_busy) |->
    autoneg_en_ff == $past(strap_an_s2) && !loopback_ff)
    else $error("straps or defaults not reloaded after reset");
  strap_reset_a: assert property ($past(srst) && !srst |->
    autoneg_en_ff == $past(strap_an_s2))
    else $error("auto-negotiation enable not taken from strap");
  loop_path_a: assert property (
    loopback_ff && !isolate_ff && !power_down_ff
    |=> mac_rxd_ff == $past(mac_txd))
    else $error("loopback data not routed to receive");
  forced_speed_a: assert property (!autoneg_en_ff |=>
    speed_100_ff == $past(speed_sel_ff))
    else $error("forced speed not applied");
  an_ignore_a: assert property (autoneg_en_ff |=>
    speed_100_ff == $past(an_speed_100)
    && full_duplex_ff == $past(an_full_duplex))
    else $error("forced bits used while negotiating");
  forced_duplex_a: assert property (!autoneg_en_ff |=>
    full_duplex_ff == $past(duplex_sel_ff))
    else $error("forced duplex not applied");
  tally_clear_a: assert property (rd_selftest && !selftest_error
    |=> tally_ff == 8'h00)
    else $error("error tally not cleared by read");
  latch_high_a: assert property (met_q[1] && !rd_energy
    |=> met_q[1])
    else $error("latched-high flag dropped before read");
  latch_low_a: assert property (!link_ok ##1 !rd_link
    |=> !link_q)
    else $error("latched-low link bit released before read");
  perm_bit_a: assert property (rd_link
    |=> reg_rdata_ff[`PBMC_LS_PERM] == `PBMC_LS_PERM_VAL)
    else $error("permanent bit changed");
  resv_zero_a: assert property (
    reg_rd && hit(reg_addr, `PBMC_OFF_BASIC_CTRL)
    |=> reg_rdata_ff[9] == 1'b0 && reg_rdata_ff[7:0] == 8'h00)
    else $error("reserved control bits read nonzero");
  power_down_a: assert property (power_down_ff |=> !core_enable_ff
    && !mac_rx_dv_ff)
    else $error("core active during power down");
  isolate_mac_a: assert property (isolate_ff |=> !mac_rx_dv_ff
    && mac_rxd_ff == 4'h0)
    else $error("mac side driven while isolated");
endmodule

// *** design/pbmc_cfg.svh ***
// named offsets, bit positions, masks, reset values and timing
// assumes a 16-bit register word and a 5-bit register address
`ifndef PBMC_CFG_SVH
`define PBMC_CFG_SVH
// register offsets
`define PBMC_OFF_BASIC_CTRL   5'h00
`define PBMC_OFF_IRQ_STATUS   5'h11
`define PBMC_OFF_IRQ_MASK     5'h12
`define PBMC_OFF_LINK_STATUS  5'h13
`define PBMC_OFF_TENBASE      5'h1a
`define PBMC_OFF_SELFTEST     5'h1b
`define PBMC_OFF_ENERGY       5'h1d
// basic mode control bit positions
`define PBMC_BC_RESET    15
`define PBMC_BC_LOOP     14
`define PBMC_BC_SPEED    13
`define PBMC_BC_ANEN     12
`define PBMC_BC_PDOWN    11
`define PBMC_BC_ISOLATE  10
`define PBMC_BC_DUPLEX   8
// write masks and bit positions of the other registers
`define PBMC_TENBASE_WMASK   16'h0043
`define PBMC_TENBASE_POL     4
`define PBMC_TENBASE_FORCE   6
`define PBMC_SELFTEST_WMASK  16'h0037
`define PBMC_TALLY_LSB       8
`define PBMC_ENERGY_WMASK    16'hf8ff
`define PBMC_ENERGY_POWER_STATE    10
`define PBMC_ENERGY_ERROR_THRESHOLD_MET      9
`define PBMC_ENERGY_DATA_THRESHOLD_MET     8
// reset values of the configuration words
`define PBMC_TENBASE_RST     16'h0000
`define PBMC_SELFTEST_RST    16'h0000
`define PBMC_ENERGY_RST      16'h0000
// link status register bits
`define PBMC_LS_LINK         2
`define PBMC_LS_PERM         0
`define PBMC_LS_PERM_VAL     1'h1
// interrupt event bits
`define PBMC_IRQ_W           5
`define PBMC_IRQ_SWRST       0
`define PBMC_IRQ_SELFTEST    1
`define PBMC_IRQ_ERR_MET     2
`define PBMC_IRQ_DATA_MET    3
`define PBMC_IRQ_LINK_LOSS   4
// software reset duration, rounded up to whole clock cycles
`define PBMC_CLK_PERIOD_NS   10
`define PBMC_SWRST_TIME_NS   1000
`define PBMC_SWRST_CYCLES \
  ((`PBMC_SWRST_TIME_NS + `PBMC_CLK_PERIOD_NS - 1) / `PBMC_CLK_PERIOD_NS)
`endif

// *** design/pbmc_pkg.sv ***
// types shared by the basic mode control block
// widths and state codes are fixed here; assumes pbmc_cfg.svh supplies the other numeric constants
package pbmc_pkg;
  typedef logic [4:0]  pbmc_addr_type;
  typedef logic [15:0] pbmc_word_type;
  typedef enum logic [1:0] {
    PBMC_IDLE = 2'b00,
    PBMC_RUN  = 2'b01,
    PBMC_DONE = 2'b11
  } pbmc_seq_state_type;
endpackage

// *** design/pbmc_latch.sv ***
// one latched status bit, latched high or latched low
// assumes live status and read pulse come from the ref_clk domain
`timescale 1ns/1ps
module pbmc_latch #(
  parameter bit ACTIVE = 1'b1
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // live condition and read release
  input  wire logic live,
  input  wire logic rd_release,
  // latched value
  output logic      value_ff
);
  // ****************************************************************
  // latch: the event level sticks until read, then follows live
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      value_ff <= ~ACTIVE;
    end else if ((live == ACTIVE) || (!rd_release && value_ff == ACTIVE))
    begin
      value_ff <= ACTIVE;
    end else begin
      value_ff <= ~ACTIVE;
    end
  end
endmodule

// *** design/pbmc_rst_seq.sv ***
// software reset sequencer: busy for a set count, then one done cycle
// assumes a one-cycle start pulse from the register logic
`timescale 1ns/1ps
`include "pbmc_cfg.svh"
module pbmc_rst_seq #(
  parameter int CYCLES = `PBMC_SWRST_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import pbmc_pkg::*;
  pbmc_seq_state_type state_ff;
  logic [15:0]        cnt_ff;

  // ****************************************************************
  // state and count
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff <= PBMC_IDLE;
      cnt_ff   <= 16'h0000;
    end else begin
      unique case (state_ff)
        PBMC_IDLE: begin
          cnt_ff <= 16'h0000;
          if (start) begin
            state_ff <= PBMC_RUN;
          end
        end
        PBMC_RUN: begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == 16'(CYCLES - 1)) begin
            state_ff <= PBMC_DONE;
          end
        end
        PBMC_DONE: begin
          state_ff <= PBMC_IDLE;
        end
        default: begin
          state_ff <= PBMC_IDLE;
        end
      endcase
    end
  end

  // status decode
  assign busy = (state_ff != PBMC_IDLE);
  assign done = (state_ff == PBMC_DONE);
endmodule

// *** tb/pbmc_top_tb.sv ***
// testbench for the basic mode control register bank
// assumes pbmc_top alone on a 100 MHz ref_clk, read data one cycle late
`timescale 1ns/1ps
module pbmc_top_tb;
  import pbmc_pkg::*;
  logic          ref_clk, srst, reg_wr, reg_rd, irq;
  pbmc_addr_type reg_addr;
  pbmc_word_type reg_wdata, reg_rdata, d;
  logic          s_an, s_spd, s_fd, an_spd, lnk, st_err, e_err, e_dat;
  logic          tx_en, rx_dv, spd, fd, an, cen, iso, lb;
  logic [3:0]    txd, rxd;
  logic [2:0]    tb_ctrl;
  logic [4:0]    st_ctrl;
  logic [12:0]   ed_ctrl;
  int            n_errors, samples_checked;
  pbmc_top i_pbmc_top (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .strap_autoneg_en(s_an),
    .strap_speed_100(s_spd), .strap_full_duplex(s_fd),
    .an_speed_100(an_spd), .an_full_duplex(1'b0), .link_ok(lnk),
    .polarity_inverted(1'b0), .selftest_error(st_err),
    .energy_power_state(1'b0), .energy_error_met_in(e_err),
    .energy_data_met_in(e_dat), .mac_txd(txd), .mac_tx_en(tx_en),
    .line_rxd(4'h5), .line_rx_dv(1'b1), .mac_rxd(rxd), .mac_rx_dv(rx_dv),
    .speed_100(spd), .full_duplex(fd), .autoneg_enable(an),
    .core_enable(cen), .isolate(iso), .loopback(lb), .tenbase_ctrl(tb_ctrl),
    .selftest_ctrl(st_ctrl), .energy_ctrl(ed_ctrl));
  // ****************************************
  // bus cycles and comparison
  // ****************************************
  task automatic wr(input pbmc_addr_type a, input pbmc_word_type v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input pbmc_addr_type a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(string n, pbmc_word_type e, pbmc_word_type g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(pbmc_addr_type a, pbmc_word_type m, e, string n);
    rd(a);
    chk(n, e, d & m);
  endtask
  // registered outputs follow a write two edges later
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rdc(5'h00, 16'hffff, 16'h1000, "ctrl reset");
    rdc(5'h1c, 16'hffff, 16'h0000, "unmapped");
    @(posedge ref_clk) lnk <= 1'b0;
    @(posedge ref_clk) lnk <= 1'b1;
    rdc(5'h13, 16'h0005, 16'h0001, "link held");
    rdc(5'h13, 16'h0005, 16'h0005, "link back");
  endtask
  task automatic t_modes;
    wr(5'h00, 16'h1100);
    settle;
    chk("an mode", 16'h0002, {14'h0, spd, fd});
    wr(5'h00, 16'h2100);
    settle;
    chk("forced", 16'h0003, {14'h0, spd, fd});
    wr(5'h00, 16'h0000);
    settle;
    chk("forced low", 16'h0000, {13'h0, an, spd, fd});
  endtask
  task automatic t_data;
    chk("line", 16'h0035, {11'h0, cen, rx_dv, rxd});
    wr(5'h00, 16'h4000);
    settle;
    // no descrambler in this model, so no loopback dead time to wait out
    chk("loop", 16'h007a, {10'h0, lb, cen, rx_dv, rxd});
    wr(5'h00, 16'h4400);
    settle;
    chk("isolate", 16'h0060, {10'h0, iso, cen, rx_dv, rxd});
    wr(5'h00, 16'h4800);
    settle;
    chk("pdown", 16'h0000, {11'h0, cen, rx_dv, rxd});
    wr(5'h00, 16'h0000);
  endtask
  task automatic t_regs;
    wr(5'h1a, 16'hffff);
    rdc(5'h1a, 16'hffff, 16'h0043, "tenbase");
    wr(5'h1b, 16'hffff);
    repeat (3) begin
      @(posedge ref_clk) st_err <= 1'b1;
      @(posedge ref_clk) st_err <= 1'b0;
    end
    rdc(5'h1b, 16'hffff, 16'h0337, "tally");
    rdc(5'h1b, 16'hffff, 16'h0037, "tally clear");
    wr(5'h1d, 16'hffff);
    @(posedge ref_clk) e_err <= 1'b1;
    @(posedge ref_clk) e_err <= 1'b0;
    rdc(5'h1d, 16'hffff, 16'hfaff, "met held");
    rdc(5'h1d, 16'hffff, 16'hf8ff, "met release");
    chk("ctrl outs", 16'hffff, {tb_ctrl, ed_ctrl});
    chk("selftest", 16'h0017, {11'h0, st_ctrl});
  endtask
  task automatic t_swrst;
    wr(5'h12, 16'h0001);
    s_an  <= 1'b0;
    s_spd <= 1'b1;
    s_fd  <= 1'b1;
    wr(5'h00, 16'hc000);
    rdc(5'h00, 16'h8000, 16'h8000, "busy");
    for (int i = 0; i < 100 && d[15] !== 1'b0; i++) rd(5'h00);
    if (d[15] !== 1'b0) begin
      n_errors++;
      end_of_test;
    end
    rdc(5'h00, 16'hffff, 16'h2100, "restrap");
    settle;
    chk("irq set", 16'h0001, {15'h0, irq});
    wr(5'h11, 16'h0001);
    settle;
    chk("irq clear", 16'h0000, {15'h0, irq});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // straps and live inputs are set at time zero, reset held four cycles
  initial begin
    {srst, s_an, an_spd, lnk, tx_en} = 5'h1f;
    {reg_wr, reg_rd, s_spd, s_fd, st_err, e_err, e_dat} = 7'h0;
    {reg_addr, reg_wdata, txd} = {5'h0, 16'h0, 4'ha};
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_modes;
    t_data;
    t_regs;
    t_swrst;
    end_of_test;
  end
endmodule
